// File: verilog/comparator_two_control.sv
// Control logic of the second analog comparator: registers, filter, events
// Functional notes
// - Enable bit powers comparator, else pins GPIO
// - Output pin enable drives result onto pin
// - Result flag reads level, zero when disabled
// - Special mode lets edges shrink timer pulse
// - Edge bit picks falling or rising trigger
// - Three-bit code picks reference level
// - Step field adds 1, 2, 4, 8
// - Supply bit picks rail or 4V source
// - Negative select routes pin or other comparator
// - De-bounce: none, one, two, four cycles
// - Selected filtered edge latches flag until cleared
// - Trigger and steady periods add step, saturate
// - Green mode latches flag without wake-up
`default_nettype none
module comparator_two_control
  import cmp2_pkg::*;
#(
  parameter int RELOAD_W = 8 // Pulse timer reload width
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic clk_en_i,
  input wire bus_req_s bus_i,
  output logic [7:0] rdata_o,
  input wire logic cmp_raw_i,
  input wire logic green_mode_i,
  input wire logic pulse_out_en_i,
  input wire logic period_end_i,
  input wire logic [7:0] reload_i,
  output logic reload_load_o,
  output logic [7:0] reload_val_o,
  output analog_ctl_s actl_o,
  output logic irq_o,
  output logic wake_o
);
  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // The saturation limit is an 8-bit figure, so other widths are refused
  if (RELOAD_W != 8) begin : g_bad_width
    $error("reload width must be eight");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sync1; // First stage of the result synchroniser
    logic sync2; // Second stage, safe to use
    logic [7:0] mode; // Mode register, result bit kept zero
    logic [AUX_W-1:0] aux; // Auxiliary register
    logic [EV_W-1:0] stat; // Sticky event bits
    logic [EV_W-1:0] mask; // Event mask, also the interrupt enable
    logic [7:0] rdata; // Read answer
    logic lvl_q; // Filtered level one cycle ago
    logic shrink_act; // A shrink sequence is running
    logic act_lvl; // Level seen at the trigger
    logic reload_ld; // Reload write pulse
    logic [7:0] reload_val; // New reload value
    logic irq; // Interrupt level
    logic wake; // Wake-up request
    analog_ctl_s actl; // Analog and pin controls
  } top_s;
  top_s r_reg;
  top_s r_next;
  logic rst_s1; // Reset release stage one
  logic rst_n; // Released reset for the whole design
  logic en; // Comparator enabled
  logic dbl; // Filtered level
  logic rise; // Filtered rising edge
  logic fall; // Filtered falling edge
  logic hit; // Qualified trigger edge
  logic can_shrink; // Shrinking allowed this cycle
  logic steady_end; // Period end with unchanged level
  logic [7:0] sum_w; // Saturated reload sum
  logic [EV_W-1:0] ev_set; // Events raised this cycle
  logic [EV_W-1:0] ev_clr; // Bits cleared by software
  logic [7:0] mode_rd; // Mode register as read

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address match, used by both the write and the read path
  function automatic logic hit_ofs(input bus_req_s b, input logic [7:0] ofs);
    hit_ofs = (b.addr == ofs);
  endfunction : hit_ofs

  // Reload plus step; holds at the top instead of wrapping
  function automatic logic [7:0] sat_add(input logic [7:0] v, input logic [1:0] s);
    logic [8:0] t;
    t = {1'b0, v} + (9'h001 << s);
    sat_add = t[8] ? RELOAD_MAX : t[7:0];
  endfunction : sat_add

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Asserts at once, releases through two flops to avoid a ragged exit
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // ----------------------------------------------------------------
  // Output filter
  // ----------------------------------------------------------------
  assign en = r_reg.mode[EN_BIT];

  // Disabled comparator feeds a low level into the filter
  cmp2_debounce u_debounce (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .ce_i(clk_en_i),
    .sel_i(r_reg.aux[DB_LSB +: 2]),
    .raw_i(en & r_reg.sync2),
    .level_o(dbl)
  );

  // ----------------------------------------------------------------
  // Edge and shrink decisions
  // ----------------------------------------------------------------
  always_comb begin
    rise = dbl & ~r_reg.lvl_q;
    fall = ~dbl & r_reg.lvl_q;
    // Falling when the edge bit is low, rising when high
    hit = en & (r_reg.mode[EDGE_BIT] ? rise : fall);
    // Only in special mode with the timer pulse output running
    can_shrink = en & r_reg.mode[SHRINK_BIT] & pulse_out_en_i;
    steady_end = r_reg.shrink_act & period_end_i & (dbl == r_reg.act_lvl);
    sum_w = sat_add(reload_i, r_reg.aux[STEP_LSB +: 2]);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    ev_set = '0;
    ev_clr = '0;
    mode_rd = r_reg.mode;
    // Result flag is the live level, forced low while disabled
    mode_rd[RES_BIT] = en & r_reg.sync2;
    // Synchroniser chain; only the second stage is read
    r_next.sync1 = cmp_raw_i;
    r_next.sync2 = r_reg.sync1;
    r_next.lvl_q = dbl;
    r_next.reload_ld = 1'b0;
    // Stop a shrink run when leaving the mode or when the level flips
    if (!can_shrink || (r_reg.shrink_act && dbl != r_reg.act_lvl)) begin
      r_next.shrink_act = 1'b0;
    end
    // First trigger starts a run and adds one step
    if (can_shrink && hit) begin
      r_next.shrink_act = 1'b1;
      r_next.act_lvl = dbl;
      r_next.reload_ld = (reload_i != RELOAD_MAX);
      r_next.reload_val = sum_w;
    end else if (can_shrink && steady_end) begin
      // Each period end with an unchanged level adds another step
      r_next.reload_ld = (reload_i != RELOAD_MAX);
      r_next.reload_val = sum_w;
    end
    ev_set[EV_EDGE] = hit;
    ev_set[EV_SHRINK] = r_next.reload_ld;
    // Register writes
    if (bus_i.wr) begin
      if (hit_ofs(bus_i, MODE_OFS)) begin
        r_next.mode = bus_i.wdata;
        r_next.mode[RES_BIT] = 1'b0; // Read-only bit
      end
      if (hit_ofs(bus_i, AUX_OFS)) begin
        r_next.aux = bus_i.wdata[AUX_W-1:0];
      end
      if (hit_ofs(bus_i, STAT_OFS)) begin
        ev_clr = bus_i.wdata[EV_W-1:0];
      end
      if (hit_ofs(bus_i, MASK_OFS)) begin
        r_next.mask = bus_i.wdata[EV_W-1:0];
      end
    end
    // Set beats clear so an event in the clearing cycle survives
    r_next.stat = (r_reg.stat & ~ev_clr) | ev_set;
    // Read answer stands for exactly one cycle
    r_next.rdata = 8'h00;
    if (bus_i.rd) begin
      if (hit_ofs(bus_i, MODE_OFS)) begin
        r_next.rdata = mode_rd;
      end else if (hit_ofs(bus_i, AUX_OFS)) begin
        r_next.rdata = {2'b00, r_reg.aux};
      end else if (hit_ofs(bus_i, STAT_OFS)) begin
        r_next.rdata = {6'h00, r_reg.stat};
      end else if (hit_ofs(bus_i, MASK_OFS)) begin
        r_next.rdata = {6'h00, r_reg.mask};
      end
    end
    // Interrupt follows the new status so it leaves with the flop
    r_next.irq = |(r_next.stat & r_next.mask);
    // Green mode keeps latching but never wakes the core
    r_next.wake = r_next.irq & ~green_mode_i;
    // Analog controls follow the new register values
    r_next.actl.power = r_next.mode[EN_BIT];
    r_next.actl.neg_pin_iso = r_next.mode[EN_BIT] & ~r_next.aux[NEG_BIT];
    r_next.actl.neg_from_other = r_next.mode[EN_BIT] & r_next.aux[NEG_BIT];
    r_next.actl.out_drive = r_next.mode[EN_BIT] & r_next.mode[OEN_BIT];
    // Second stage only; the first stage may still be settling
    r_next.actl.out_level = r_next.mode[EN_BIT] & r_reg.sync2;
    r_next.actl.ref_level = r_next.mode[REF_LSB +: REF_W];
    r_next.actl.ref_4v = r_next.aux[SUP_BIT];
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Everything holds while the clock enable is low
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
      r_reg.mode <= MODE_RST;
      r_reg.aux <= AUX_RST;
      r_reg.stat <= EV_RST;
      r_reg.mask <= EV_RST;
    end else if (clk_en_i) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign rdata_o = r_reg.rdata;
  assign reload_load_o = r_reg.reload_ld;
  assign reload_val_o = r_reg.reload_val;
  assign actl_o = r_reg.actl;
  assign irq_o = r_reg.irq;
  assign wake_o = r_reg.wake;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n || !clk_en_i);

  // Mode register write seen on the bus
  sequence s_mode_wr;
    bus_i.wr && bus_i.addr == MODE_OFS;
  endsequence
  // Selected edge seen on the filtered level
  sequence s_sel_edge;
    en && (r_reg.mode[EDGE_BIT] ? (dbl && !r_reg.lvl_q) : (!dbl && r_reg.lvl_q));
  endsequence

  AST_ENABLE_POWER: assert property (
    s_mode_wr |=> (actl_o.power == $past(bus_i.wdata[EN_BIT]) &&
      actl_o.neg_pin_iso == ($past(bus_i.wdata[EN_BIT]) && !r_reg.aux[NEG_BIT])))
    else $error("enable did not reach the analog controls");
  AST_OUT_PIN: assert property (
    actl_o.out_drive == (r_reg.mode[EN_BIT] && r_reg.mode[OEN_BIT]))
    else $error("output pin drive wrong");
  AST_RESULT_OFF: assert property (
    (bus_i.rd && bus_i.addr == MODE_OFS && !en) |=> !rdata_o[RES_BIT])
    else $error("result flag set while disabled");
  AST_NO_SHRINK: assert property (
    !r_reg.mode[SHRINK_BIT] |=> !reload_load_o)
    else $error("reload written outside special mode");
  AST_EDGE_FLAG: assert property (
    s_sel_edge |=> r_reg.stat[EV_EDGE] ##1 (r_reg.stat[EV_EDGE] || $past(bus_i.wr)))
    else $error("edge flag not latched");
  AST_RELOAD_SAT: assert property (
    reload_load_o |-> (reload_val_o == $past(sum_w) && $past(reload_i) != RELOAD_MAX))
    else $error("reload value not the saturated sum");
  AST_GREEN_NO_WAKE: assert property (
    green_mode_i |=> !wake_o)
    else $error("wake raised in green mode");
  AST_AUX_TOP: assert property (
    (bus_i.rd && bus_i.addr == AUX_OFS) |=> rdata_o[7:6] == 2'b00)
    else $error("aux top bits not zero");
  AST_IRQ_LEVEL: assert property (
    irq_o == |(r_reg.stat & r_reg.mask))
    else $error("interrupt level disagrees with status");

  // ----------------------------------------------------------------
  // Checks on the analog controls, result bit, edge flag, filter and shrink path
  // ----------------------------------------------------------------
  // Shrink trigger as the next-state logic sees it
  sequence s_shrink_trig;
    can_shrink && hit && reload_i != RELOAD_MAX;
  endsequence
  // A disabled comparator leaves every pin to the port logic
  AST_PINS_OFF: assert property (
    !r_reg.mode[EN_BIT] |-> (!actl_o.power && !actl_o.neg_pin_iso &&
      !actl_o.neg_from_other && !actl_o.out_drive))
    else $error("pins not released while disabled");
  // The result bit never keeps a written value
  AST_MODE_RO: assert property (
    s_mode_wr |=> !r_reg.mode[RES_BIT])
    else $error("result bit stored a write");
  // A rising level with falling edges selected raises nothing
  AST_WRONG_EDGE: assert property (
    (en && !r_reg.mode[EDGE_BIT] && dbl && !r_reg.lvl_q && !r_reg.stat[EV_EDGE]) |=>
      !r_reg.stat[EV_EDGE])
    else $error("edge flag raised by the wrong edge");
  // The reference code reaches the divider unchanged
  AST_REF_LEVEL: assert property (
    s_mode_wr |=> actl_o.ref_level == $past(bus_i.wdata[REF_LSB +: REF_W]))
    else $error("reference code not passed on");
  // Away from the top each load adds exactly one step
  AST_STEP_SIZE: assert property (
    (reload_load_o && $past(reload_i) < 8'hF8) |->
      reload_val_o == $past(reload_i) + (8'h01 << $past(r_reg.aux[STEP_LSB +: 2])))
    else $error("shrink step size wrong");
  // The supply bit reaches the divider unchanged
  AST_REF_SUPPLY: assert property (
    (bus_i.wr && bus_i.addr == AUX_OFS) |=> actl_o.ref_4v == $past(bus_i.wdata[SUP_BIT]))
    else $error("reference supply not passed on");
  // Routing from the other comparator frees the negative pin
  AST_NEG_OTHER: assert property (
    actl_o.neg_from_other |-> (actl_o.power && !actl_o.neg_pin_iso))
    else $error("negative input routing wrong");
  // Without filtering the edge logic sees the synchronised level at once
  AST_DB_BYPASS: assert property (
    (r_reg.aux[DB_LSB +: 2] == 2'b00) |-> dbl == (en && r_reg.sync2))
    else $error("filter bypass delays the level");
  // Every qualified trigger below the top loads the timer
  AST_SHRINK_START: assert property (
    s_shrink_trig |=> reload_load_o)
    else $error("trigger did not load the timer");
  // The edge flag rises only after a qualified edge
  AST_FLAG_ONLY_ON_HIT: assert property (
    (!r_reg.stat[EV_EDGE] && !hit) |=> !r_reg.stat[EV_EDGE])
    else $error("edge flag set without an edge");
endmodule : comparator_two_control
`default_nettype wire

// File: verilog/cmp2_pkg.sv
// Shared constants and carrier types for the second comparator control block
`default_nettype none
package cmp2_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] AUX_OFS = 8'h9B;
  localparam logic [7:0] MODE_OFS = 8'h9E;
  localparam logic [7:0] STAT_OFS = 8'hA0;
  localparam logic [7:0] MASK_OFS = 8'hA1;
  // ----------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------
  localparam int EN_BIT = 7;
  localparam int OEN_BIT = 6;
  localparam int RES_BIT = 5;
  localparam int SHRINK_BIT = 4;
  localparam int EDGE_BIT = 3;
  localparam int REF_LSB = 0;
  localparam int REF_W = 3;
  localparam logic [7:0] MODE_RST = 8'h00;
  // ----------------------------------------------------------------
  // Auxiliary register fields
  // ----------------------------------------------------------------
  localparam int STEP_LSB = 4;
  localparam int SUP_BIT = 3;
  localparam int NEG_BIT = 2;
  localparam int DB_LSB = 0;
  localparam int AUX_W = 6;
  localparam logic [5:0] AUX_RST = 6'h00;
  // ----------------------------------------------------------------
  // Event bits of status and mask
  // ----------------------------------------------------------------
  localparam int EV_EDGE = 0;
  localparam int EV_SHRINK = 1;
  localparam int EV_W = 2;
  localparam logic [1:0] EV_RST = 2'h0;
  // ----------------------------------------------------------------
  // Timing and limits
  // ----------------------------------------------------------------
  localparam int DB_CNT_W = 3;
  localparam logic [2:0] DB_CYC_ONE = 3'h1;
  localparam logic [2:0] DB_CYC_TWO = 3'h2;
  localparam logic [2:0] DB_CYC_FOUR = 3'h4;
  localparam logic [7:0] RELOAD_MAX = 8'hFF;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bus_req_s;
  typedef struct packed {
    logic power;
    logic neg_pin_iso;
    logic neg_from_other;
    logic out_drive;
    logic out_level;
    logic [2:0] ref_level;
    logic ref_4v;
  } analog_ctl_s;
endpackage : cmp2_pkg
`default_nettype wire

// File: verilog/cmp2_debounce.sv
// Output de-bounce filter for the comparator result
`default_nettype none
module cmp2_debounce
  import cmp2_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [1:0] sel_i,
  input wire logic raw_i,
  output logic level_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lvl;
    logic [DB_CNT_W-1:0] cnt;
  } db_s;
  db_s r_reg;
  db_s r_next;
  logic [DB_CNT_W-1:0] need;

  // Stable-cycle count for each selection
  function automatic logic [DB_CNT_W-1:0] db_len(input logic [1:0] s);
    case (s)
      2'b01: db_len = DB_CYC_ONE;
      2'b10: db_len = DB_CYC_TWO;
      default: db_len = DB_CYC_FOUR;
    endcase
  endfunction : db_len

  // Accept a new level only after it stayed for the chosen time
  always_comb begin
    r_next = r_reg;
    need = db_len(sel_i);
    if (sel_i == 2'b00) begin
      r_next.lvl = raw_i;
      r_next.cnt = '0;
    end else if (raw_i == r_reg.lvl) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt + 3'h1 >= need) begin
      r_next.lvl = raw_i;
      r_next.cnt = '0;
    end else begin
      r_next.cnt = r_reg.cnt + 3'h1;
    end
  end

  // Register, frozen while the clock enable is low
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else if (ce_i) begin
      r_reg <= r_next;
    end
  end

  // Bypass gives the raw level with no delay when filtering is off
  assign level_o = (sel_i == 2'b00) ? raw_i : r_reg.lvl;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_DB_FOUR: assert property (
    @(posedge clk_i) disable iff (!rst_n_i || !ce_i)
    (sel_i == 2'b11 && $changed(r_reg.lvl)) |->
      ($past(raw_i, 1) == r_reg.lvl && $past(raw_i, 4) == r_reg.lvl))
    else $error("level accepted before four stable cycles");
endmodule : cmp2_debounce
`default_nettype wire

// File: tb/cmp2_analog_model.sv
// Analog comparator core and pulse timer that sit beyond the control block
`default_nettype none
module cmp2_analog_model
  import cmp2_pkg::*;
#(
  parameter int PERIOD = 8 // Timer period in clock cycles, short to keep runs brief
) (
  input wire logic clk_i,
  input wire analog_ctl_s actl_i,
  input wire logic [2:0] neg_lvl_i,
  input wire logic [2:0] other_lvl_i,
  input wire logic load_i,
  input wire logic [7:0] val_i,
  input wire logic preset_i,
  input wire logic [7:0] preset_val_i,
  output logic raw_o,
  output logic period_end_o,
  output logic [7:0] reload_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0; // Free running period counter
  logic [7:0] reload_q = 8'h00; // Timer reload register
  // ----------------------------------------------------------------
  // Comparator: high only while powered and V+ above V-
  // ----------------------------------------------------------------
  always_comb begin
    // Unpowered core drives low, so a stale high never leaks out
    raw_o = actl_i.power &&
      (actl_i.ref_level > (actl_i.neg_from_other ? other_lvl_i : neg_lvl_i));
  end
  // Timer keeps the bench preset first, else whatever reload value the control block hands over
  always_ff @(posedge clk_i) begin
    cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
    period_end_o <= (cnt == PERIOD - 1);
    if (preset_i) begin
      reload_q <= preset_val_i;
    end else if (load_i) begin
      reload_q <= val_i;
    end
  end
  assign reload_o = reload_q;
endmodule : cmp2_analog_model
`default_nettype wire

// File: tb/tb_comparator_two_control.sv
// Self-checking bench for the second comparator control block
`default_nettype none
module tb_comparator_two_control;
  import cmp2_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  bus_req_s bus = '0; // Register bus request
  logic green = 1'b0;
  logic pout_en = 1'b0;
  logic [2:0] neg_lvl = 3'h7; // Level on the negative pin
  logic [2:0] other_lvl = 3'h7; // Level from the other comparator
  logic preset = 1'b0;
  logic [7:0] preset_val = 8'h00;
  logic [7:0] rdata, rval, reload, v;
  logic rload, irq, wake, raw, pend;
  analog_ctl_s actl;
  int mismatches = 0;
  int cmp_count = 0;
  int lat[4];
  int n;
  logic [7:0] ofs[5] = '{AUX_OFS, MODE_OFS, STAT_OFS, MASK_OFS, 8'h50}; // Reset readback places
  int dly[4] = '{0, 1, 2, 4}; // Extra delay per filter length
  comparator_two_control #(.RELOAD_W(8)) comparator_two_control_inst (
    .core_clk_i(core_clk), .resetn_i(resetn), .clk_en_i(1'b1), .bus_i(bus),
    .rdata_o(rdata), .cmp_raw_i(raw), .green_mode_i(green), .pulse_out_en_i(pout_en),
    .period_end_i(pend), .reload_i(reload), .reload_load_o(rload),
    .reload_val_o(rval), .actl_o(actl), .irq_o(irq), .wake_o(wake));
  cmp2_analog_model #(.PERIOD(8)) cmp2_analog_model_inst (
    .clk_i(core_clk), .actl_i(actl), .neg_lvl_i(neg_lvl), .other_lvl_i(other_lvl),
    .load_i(rload), .val_i(rval), .preset_i(preset), .preset_val_i(preset_val),
    .raw_o(raw), .period_end_o(pend), .reload_o(reload));
  // 50 MHz clock
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // ----------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic cyc(input int c);
    repeat (c) @(posedge core_clk);
  endtask : cyc
  // One-cycle write strobe; a gap edge follows so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe, sampled mid-cycle
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done
  // Watchdog: the sequence needs well under a tenth of this span
  initial begin
    #400us;
    mismatches++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(20);
    resetn <= 1'b1;
    cyc(4);
    // Every register and an unmapped place read zero after reset
    for (int i = 0; i < 5; i++) begin
      rd(ofs[i], v);
      chk("reset value", v, 16'h0000);
    end
    chk("analog controls after reset", actl, 16'h0000);
    wr(8'h50, 8'hFF);
    rd(8'h50, v);
    chk("unmapped", v, 16'h0000);
    wr(AUX_OFS, 8'hFF); // mode still cleared, 4V power taken as on
    rd(AUX_OFS, v);
    chk("aux top bits", v, 16'h003F);
    // Result bit ignores the write; V+ code 7 equals V- 7 so it reads low
    wr(MODE_OFS, 8'hFF); // pin path taken as isolated outside the block
    rd(MODE_OFS, v);
    chk("mode readback", v, 16'h00DF);
    chk("controls, other source, 4V", actl, 16'h016F);
    wr(AUX_OFS, 8'h00);
    wr(MODE_OFS, 8'h80);
    cyc(2);
    chk("controls, pin source, rail", actl, 16'h0180);
    for (int i = 0; i < 8; i++) begin
      wr(MODE_OFS, 8'h80 | 8'(i));
      cyc(2);
      chk("ref level", actl.ref_level, 16'(i));
    end
    // Result flag follows the comparator and drops with the enable
    wr(MODE_OFS, 8'hC4);
    neg_lvl <= 3'h0;
    cyc(6);
    rd(MODE_OFS, v);
    chk("result high", v, 16'h00E4);
    chk("pin drive and level", {actl.out_drive, actl.out_level}, 16'h0003);
    wr(MODE_OFS, 8'h44);
    rd(MODE_OFS, v);
    chk("result disabled", v, 16'h0044);
    chk("pin released", actl.out_drive, 16'h0000);
    // Rising edge latency per filter length, relative to no filter
    wr(STAT_OFS, 8'h03);
    wr(MASK_OFS, 8'h01);
    wr(MODE_OFS, 8'h8C);
    for (int d = 0; d < 4; d++) begin
      wr(AUX_OFS, 8'(d));
      neg_lvl <= 3'h7;
      cyc(12);
      wr(STAT_OFS, 8'h03);
      cyc(2);
      chk("irq cleared", irq, 16'h0000);
      @(posedge core_clk);
      neg_lvl <= 3'h0;
      n = 0;
      // Look mid-cycle so the flop update never races the look
      while (irq !== 1'b1 && n < 30) begin
        @(negedge core_clk);
        n++;
      end
      lat[d] = n;
      chk("filter delay", 16'(lat[d] - lat[0]), 16'(dly[d]));
      cyc(10);
      rd(STAT_OFS, v);
      chk("edge flag sticky", v, 16'h0001);
    end
    wr(STAT_OFS, 8'h01);
    cyc(2);
    chk("irq after clear", irq, 16'h0000);
    // Falling edge selected: high to low flags, low to high does not
    wr(AUX_OFS, 8'h00);
    wr(MODE_OFS, 8'h84);
    neg_lvl <= 3'h7;
    cyc(8);
    rd(STAT_OFS, v);
    chk("falling flagged", v, 16'h0001);
    wr(STAT_OFS, 8'h01);
    neg_lvl <= 3'h0;
    cyc(8);
    rd(STAT_OFS, v);
    chk("rising ignored", v, 16'h0000);
    // Masked event latches without a request; green mode suppresses wake
    wr(MASK_OFS, 8'h00);
    green <= 1'b1;
    neg_lvl <= 3'h7;
    cyc(8);
    chk("masked irq", {irq, wake}, 16'h0000);
    wr(MASK_OFS, 8'h01);
    cyc(3);
    chk("green irq no wake", {irq, wake}, 16'h0002);
    green <= 1'b0;
    cyc(3);
    chk("wake after green", {irq, wake}, 16'h0003);
    wr(STAT_OFS, 8'h03);
    // Normal mode: an edge leaves the timer alone
    pout_en <= 1'b1;
    wr(MODE_OFS, 8'h8C);
    neg_lvl <= 3'h0;
    n = 0;
    repeat (40) begin
      @(posedge core_clk);
      #1 n += int'(rload === 1'b1);
    end
    chk("no shrink in normal mode", 16'(n), 16'h0000);
    // Special mode: first load adds the step, later periods add steps until the reload saturates
    for (int s = 0; s < 4; s++) begin
      neg_lvl <= 3'h7;
      wr(AUX_OFS, 8'(s << 4));
      wr(MODE_OFS, 8'h9C);
      wr(STAT_OFS, 8'h03);
      preset <= 1'b1;
      preset_val <= 8'hF0;
      cyc(1);
      preset <= 1'b0;
      cyc(10);
      neg_lvl <= 3'h0;
      n = 0;
      do begin
        @(posedge core_clk);
        #1 n++;
      end while (rload !== 1'b1 && n < 20);
      chk("first shrink step", rval, 16'(8'hF0 + (8'h01 << s)));
      n = 0;
      while (reload !== 8'hFF && n < 400) begin
        @(posedge core_clk);
        n++;
      end
      cyc(30);
      chk("reload saturates", reload, 16'h00FF);
      rd(STAT_OFS, v);
      chk("shrink event", v[EV_SHRINK], 16'h0001);
    end
    test_done();
  end
endmodule : tb_comparator_two_control
`default_nettype wire
